//--- gdbirq_defs.svh
`ifndef GDBIRQ_DEFS_SVH
`define GDBIRQ_DEFS_SVH
`define GDBIRQ_OFS_DEBOUNCE  12'h00c
`define GDBIRQ_OFS_POLARITY  12'h010
`define GDBIRQ_OFS_SENSE     12'h014
`define GDBIRQ_OFS_IRQ_SET   12'h018
`define GDBIRQ_OFS_IRQ_CLR   12'h01c
`define GDBIRQ_OFS_IRQ_MASK  12'h020
`define GDBIRQ_OFS_RAW       12'h024
`define GDBIRQ_OFS_STATUS    12'h028
`define GDBIRQ_PIN_DEBOUNCE_ENABLE_LSB      16
`define GDBIRQ_SPT_LSB       8
`define GDBIRQ_SPT_MSB       15
`define GDBIRQ_CNT_MSB       2
`define GDBIRQ_BOTH_LSB      16
`define GDBIRQ_RESET_VAL     32'h0000_0000
`endif

//--- gdbirq_filter.sv
`timescale 1ns/10ps
// one-pin debounce: samples on the shared tick, passes a level after enough equal samples
module gdbirq_filter (
  input  wire logic                  ref_clk,
  input  wire logic                  rstn,
  input  wire logic                  sampleTick,
  input  wire logic                  pinIn,
  input  wire gdbirq_pkg::gdbirq_count_t matchCount,
  output logic                       filtOut
);
  logic       filtOut_ff;
  logic       lastSample_ff;
  logic [3:0] agree_ff;
  wire        same     = (pinIn == lastSample_ff);
  wire  [3:0] need     = {1'b0, matchCount} + 4'h1;
  wire  [3:0] nxt_agree = same ? ((agree_ff < need) ? agree_ff + 4'h1 : agree_ff) : 4'h1;
  assign filtOut = filtOut_ff;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      filtOut_ff    <= 1'b0;
      lastSample_ff <= 1'b0;
      agree_ff      <= 4'h0;
    end else if (sampleTick) begin
      lastSample_ff <= pinIn;
      agree_ff      <= nxt_agree;
      if (nxt_agree >= need) begin
        filtOut_ff <= pinIn;
      end
    end
  end
  property p_no_change_without_tick;
    @(posedge ref_clk) disable iff (!rstn) !$past(sampleTick) |-> $stable(filtOut_ff);
  endproperty
  a_no_change_without_tick: assert property (p_no_change_without_tick)
    else $error("filter output moved without a sample");
endmodule : gdbirq_filter

//--- gdbirq_pin_model.sv
`timescale 1ns/10ps
// drives the port pins: a steady level, plus an optional short inverted pulse
module gdbirq_pin_model (
  input  wire logic        ref_clk,
  input  wire logic [15:0] level,
  input  wire logic [15:0] pulseMask,
  input  wire logic [7:0]  pulseLen,
  input  wire logic        pulseGo,
  output logic      [15:0] pinOut
);
  logic [7:0] pulseCnt_ff = 8'h00;
  always @(posedge ref_clk) begin
    if (pulseGo) begin
      pulseCnt_ff <= pulseLen;
    end else if (pulseCnt_ff != 8'h00) begin
      pulseCnt_ff <= pulseCnt_ff - 8'h01;
    end
  end
  assign pinOut = (pulseCnt_ff != 8'h00) ? (level ^ pulseMask) : level;
endmodule : gdbirq_pin_model

//--- gdbirq_pkg.sv
package gdbirq_pkg;
  typedef logic [7:0] gdbirq_period_t;
  typedef logic [2:0] gdbirq_count_t;
endpackage : gdbirq_pkg

//--- gdbirq_top.sv
// Chosen here: register access over APB.
`timescale 1ns/10ps
`include "gdbirq_defs.svh"
module gdbirq_top #(
  parameter int PINS = 16
) (
  input  wire logic            ref_clk,
  input  wire logic            rstn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [11:0]     paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  input  wire logic [PINS-1:0] pinIn,
  output logic      [PINS-1:0] pinState,
  output logic                 irqOut
);
  if (PINS != 16) begin : gPinsCheck
    $error("gdbirq_top serves exactly 16 pins");
  end
  logic [31:0]     debounce_ff;
  logic [31:0]     polarity_ff;
  logic [15:0]     sense_ff;
  logic [15:0]     irqArm_ff;
  logic [15:0]     raw_ff;
  logic [15:0]     pend_ff;
  logic [15:0]     sync1_ff;
  logic [15:0]     sync2_ff;
  logic [15:0]     prev_ff;
  logic [7:0]      divCnt_ff;
  logic [31:0]     prdata_ff;
  wire  [15:0]     filtered;
  wire  [15:0]     pin_debounce_enable      = debounce_ff[31:`GDBIRQ_PIN_DEBOUNCE_ENABLE_LSB];
  wire  [7:0]      period    = debounce_ff[`GDBIRQ_SPT_MSB:`GDBIRQ_SPT_LSB];
  wire  [2:0]      matchCnt  = debounce_ff[`GDBIRQ_CNT_MSB:0];
  wire  [15:0]     bothEdge  = polarity_ff[31:`GDBIRQ_BOTH_LSB];
  wire  [15:0]     trigPol   = polarity_ff[15:0];
  wire             acc       = psel & penable;
  wire             wrAcc     = acc & pwrite;
  wire             rdAcc     = acc & ~pwrite;
  // one aligned word per register
  function automatic logic addrHit(input logic [11:0] addr, input logic [11:0] ofs);
    addrHit = (addr == ofs);
  endfunction : addrHit
  wire             hitDb     = addrHit(paddr, `GDBIRQ_OFS_DEBOUNCE);
  wire             hitPol    = addrHit(paddr, `GDBIRQ_OFS_POLARITY);
  wire             hitSense  = addrHit(paddr, `GDBIRQ_OFS_SENSE);
  wire             hitSet    = addrHit(paddr, `GDBIRQ_OFS_IRQ_SET);
  wire             hitClr    = addrHit(paddr, `GDBIRQ_OFS_IRQ_CLR);
  wire             hitMask   = addrHit(paddr, `GDBIRQ_OFS_IRQ_MASK);
  wire             hitRaw    = addrHit(paddr, `GDBIRQ_OFS_RAW);
  wire             hitStat   = addrHit(paddr, `GDBIRQ_OFS_STATUS);
  wire             mapped    = hitDb | hitPol | hitSense | hitSet | hitClr | hitMask |
                               hitRaw | hitStat;
  // one tick per period plus one
  wire             sampleTick = (divCnt_ff >= period);
  wire  [15:0]     detIn     = (pin_debounce_enable & filtered) | (~pin_debounce_enable & sync2_ff);
  wire  [15:0]     rise      = detIn & ~prev_ff;
  wire  [15:0]     fall      = ~detIn & prev_ff;
  // polarity picks edge direction or level
  wire  [15:0]     edgeHit   = (bothEdge & (rise | fall)) |
                               (~bothEdge & ((trigPol & rise) | (~trigPol & fall)));
  wire  [15:0]     levelHit  = (trigPol & detIn) | (~trigPol & ~detIn);
  // edge or level chosen per pin
  wire  [15:0]     trig      = (sense_ff & levelHit) | (~sense_ff & edgeHit);
  wire  [15:0]     clrStat   = (wrAcc && hitStat) ? pwdata[15:0] : 16'h0000;
  wire  [31:0]     rdMux     = hitDb    ? {debounce_ff[31:8], 5'h00, debounce_ff[2:0]} :
                               hitPol   ? polarity_ff :
                               hitSense ? {16'h0000, sense_ff} :
                               hitMask  ? {16'h0000, irqArm_ff} :
                               hitRaw   ? {16'h0000, raw_ff} :
                               hitStat  ? {16'h0000, pend_ff} : 32'h0000_0000;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~mapped;
  assign prdata   = prdata_ff;
  assign pinState = detIn;
  assign irqOut   = |pend_ff;
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gFilt
      gdbirq_filter uFilt (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .sampleTick (sampleTick & pin_debounce_enable[g]),
        .pinIn      (sync2_ff[g]),
        .matchCount (matchCnt),
        .filtOut    (filtered[g])
      );
    end
  endgenerate
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_ff  <= 16'h0000;
      sync2_ff  <= 16'h0000;
      prev_ff   <= 16'h0000;
      divCnt_ff <= 8'h00;
    end else begin
      sync1_ff  <= pinIn;
      sync2_ff  <= sync1_ff;
      prev_ff   <= detIn;
      divCnt_ff <= sampleTick ? 8'h00 : divCnt_ff + 8'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      debounce_ff <= `GDBIRQ_RESET_VAL;
      polarity_ff <= `GDBIRQ_RESET_VAL;
      sense_ff    <= 16'h0000;
    end else if (wrAcc) begin
      if (hitDb) debounce_ff <= {pwdata[31:8], 5'h00, pwdata[2:0]};
      if (hitPol) polarity_ff <= pwdata;
      if (hitSense) sense_ff <= pwdata[15:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irqArm_ff <= 16'h0000;
    end else if (wrAcc && hitSet) begin
      irqArm_ff <= irqArm_ff | pwdata[15:0];
    end else if (wrAcc && hitClr) begin
      irqArm_ff <= irqArm_ff & ~pwdata[15:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      raw_ff    <= 16'h0000;
      pend_ff   <= 16'h0000;
      prdata_ff <= 32'h0000_0000;
    end else begin
      raw_ff    <= (raw_ff & ~clrStat) | trig;
      pend_ff   <= (pend_ff & ~clrStat) | (trig & irqArm_ff);
      prdata_ff <= (psel & ~penable & ~pwrite) ? rdMux : prdata_ff;
    end
  end
  property p_set_beats_clear;
    @(posedge ref_clk) disable iff (!rstn) (trig[0] && irqArm_ff[0]) |=> pend_ff[0];
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("pending bit lost on trigger");
  property p_unarmed_no_pend;
    @(posedge ref_clk) disable iff (!rstn) (!pend_ff[1] && !irqArm_ff[1]) |=> !pend_ff[1];
  endproperty
  a_unarmed_no_pend: assert property (p_unarmed_no_pend)
    else $error("unarmed pin became pending");
  property p_raw_any;
    @(posedge ref_clk) disable iff (!rstn) trig[2] |=> raw_ff[2];
  endproperty
  a_raw_any: assert property (p_raw_any)
    else $error("raw status missed trigger");
  property p_irq_level;
    @(posedge ref_clk) disable iff (!rstn) irqOut == (pend_ff != 16'h0000);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with pending");
  property p_tick_spacing;
    @(posedge ref_clk) disable iff (!rstn) (sampleTick && period == 8'h05 && $stable(period))
      |=> !sampleTick [*5] ##1 (sampleTick || period != 8'h05);
  endproperty
  a_tick_spacing: assert property (p_tick_spacing)
    else $error("sample period off");
  property p_clear_writes;
    @(posedge ref_clk) disable iff (!rstn)
      (wrAcc && hitClr) |=> (irqArm_ff & $past(pwdata[15:0])) == 16'h0000;
  endproperty
  a_clear_writes: assert property (p_clear_writes)
    else $error("disable did not disarm");
  property p_level_sense;
    @(posedge ref_clk) disable iff (!rstn) (sense_ff[4] && trigPol[4] && detIn[4]) |=> raw_ff[4];
  endproperty
  a_level_sense: assert property (p_level_sense)
    else $error("level trigger missed");
  property p_raw_pass;
    @(posedge ref_clk) disable iff (!rstn) !pin_debounce_enable[5] |-> pinState[5] == sync2_ff[5];
  endproperty
  a_raw_pass: assert property (p_raw_pass)
    else $error("unfiltered pin not passed");
  property p_read_raw;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitRaw) |-> prdata_ff == {16'h0000, $past(raw_ff)};
  endproperty
  a_read_raw: assert property (p_read_raw)
    else $error("raw status read wrong");
  property p_read_status;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitStat) |-> prdata_ff == {16'h0000, $past(pend_ff)};
  endproperty
  a_read_status: assert property (p_read_status)
    else $error("masked status read wrong");
  property p_read_mask;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitMask) |-> prdata_ff == {16'h0000, $past(irqArm_ff)};
  endproperty
  a_read_mask: assert property (p_read_mask)
    else $error("enable mask read wrong");
  property p_set_reads_zero;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitSet) |-> prdata_ff == 32'h0000_0000;
  endproperty
  a_set_reads_zero: assert property (p_set_reads_zero)
    else $error("write-only enable set read back");
  property p_clr_reads_zero;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitClr) |-> prdata_ff == 32'h0000_0000;
  endproperty
  a_clr_reads_zero: assert property (p_clr_reads_zero)
    else $error("write-only enable clear read back");
  property p_dbc_fields;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitDb) |-> (prdata_ff[7:3] == 5'h00) && (prdata_ff[2:0] == $past(matchCnt));
  endproperty
  a_dbc_fields: assert property (p_dbc_fields)
    else $error("match count field read wrong");
  property p_sense_read;
    @(posedge ref_clk) disable iff (!rstn)
      (rdAcc && hitSense) |-> prdata_ff == {16'h0000, $past(sense_ff)};
  endproperty
  a_sense_read: assert property (p_sense_read)
    else $error("sense type read wrong");
  property p_reset_zero;
    @(posedge ref_clk)
      !rstn |-> (debounce_ff == 32'h0000_0000) && (polarity_ff == 32'h0000_0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("config not zero in reset");
  property p_arm_set;
    @(posedge ref_clk) disable iff (!rstn)
      (wrAcc && hitSet) |=> (irqArm_ff & $past(pwdata[15:0])) == $past(pwdata[15:0]);
  endproperty
  a_arm_set: assert property (p_arm_set)
    else $error("enable set did not arm");
  property p_pend_needs_arm;
    @(posedge ref_clk) disable iff (!rstn)
      (pend_ff & ~$past(pend_ff) & ~$past(irqArm_ff)) == 16'h0000;
  endproperty
  a_pend_needs_arm: assert property (p_pend_needs_arm)
    else $error("pending set on unarmed pin");
  property p_w1c;
    @(posedge ref_clk) disable iff (!rstn)
      (wrAcc && hitStat) |=> (pend_ff & $past(pwdata[15:0]) & ~$past(trig)) == 16'h0000;
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear");
  property p_write_zero;
    @(posedge ref_clk) disable iff (!rstn)
      (wrAcc && hitStat) |=> ($past(pend_ff) & ~$past(pwdata[15:0]) & ~pend_ff) == 16'h0000;
  endproperty
  a_write_zero: assert property (p_write_zero)
    else $error("write zero cleared a bit");
  property p_fall_edge;
    @(posedge ref_clk) disable iff (!rstn)
      (!sense_ff[0] && !bothEdge[0] && !trigPol[0] && prev_ff[0] && !detIn[0]) |=> raw_ff[0];
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling edge missed");
  property p_rise_quiet;
    @(posedge ref_clk) disable iff (!rstn) (!sense_ff[0] && !bothEdge[0] && !trigPol[0] &&
      !raw_ff[0] && !(prev_ff[0] && !detIn[0])) |=> !raw_ff[0];
  endproperty
  a_rise_quiet: assert property (p_rise_quiet)
    else $error("falling polarity fired without a fall");
  property p_rise_edge;
    @(posedge ref_clk) disable iff (!rstn)
      (!sense_ff[3] && !bothEdge[3] && trigPol[3] && !prev_ff[3] && detIn[3]) |=> raw_ff[3];
  endproperty
  a_rise_edge: assert property (p_rise_edge)
    else $error("rising edge missed");
  property p_both_edge;
    @(posedge ref_clk) disable iff (!rstn)
      (!sense_ff[2] && bothEdge[2] && (prev_ff[2] != detIn[2])) |=> raw_ff[2];
  endproperty
  a_both_edge: assert property (p_both_edge)
    else $error("both-edge trigger missed");
  property p_filter_path;
    @(posedge ref_clk) disable iff (!rstn)
      pin_debounce_enable[5] |-> pinState[5] == filtered[5];
  endproperty
  a_filter_path: assert property (p_filter_path)
    else $error("debounced pin bypassed filter");
  property p_tick_zero;
    @(posedge ref_clk) disable iff (!rstn)
      (period == 8'h00) |-> sampleTick;
  endproperty
  a_tick_zero: assert property (p_tick_zero)
    else $error("zero period did not sample every clock");
  property p_div_range;
    @(posedge ref_clk) disable iff (!rstn)
      (divCnt_ff <= period) || $changed(period);
  endproperty
  a_div_range: assert property (p_div_range)
    else $error("sample divider overran period");
endmodule : gdbirq_top

//--- tb_top.sv
`timescale 1ns/10ps
`include "gdbirq_defs.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, irqOut, err, pulseGo;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pinIn, pinState, level, pulseMask;
  logic [7:0]  pulseLen;
  int          failures, comparisons;
  gdbirq_top u_dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinState(pinState), .irqOut(irqOut));
  gdbirq_pin_model u_pins (.ref_clk(ref_clk), .level(level), .pulseMask(pulseMask),
    .pulseLen(pulseLen), .pulseGo(pulseGo), .pinOut(pinIn));
  task automatic stop_test();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic we, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= we; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin @(posedge ref_clk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  task automatic chkrd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chkrd
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    #200000;
    failures++;
    stop_test();
  end
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; level = 16'hffe7; pulseMask = 16'h0020; pulseLen = 8'h03;
    pulseGo = 1'b0; failures = 0; comparisons = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    chkrd(`GDBIRQ_OFS_DEBOUNCE, 32'h0, "debounce reset");
    chkrd(`GDBIRQ_OFS_POLARITY, 32'h0, "polarity reset");
    chkrd(`GDBIRQ_OFS_SENSE, 32'h0, "sense reset");
    chkrd(`GDBIRQ_OFS_IRQ_SET, 32'h0, "enable set reads zero");
    apb(1'b1, `GDBIRQ_OFS_DEBOUNCE, 32'hffff_ffff);
    chkrd(`GDBIRQ_OFS_DEBOUNCE, 32'hffff_ff07, "debounce fields");
    apb(1'b1, `GDBIRQ_OFS_POLARITY, 32'hffff_ffff);
    chkrd(`GDBIRQ_OFS_POLARITY, 32'hffff_ffff, "polarity fields");
    apb(1'b1, `GDBIRQ_OFS_SENSE, 32'hffff_ffff);
    chkrd(`GDBIRQ_OFS_SENSE, 32'h0000_ffff, "sense fields");
    apb(1'b1, 12'h100, 32'h1);
    `CHK("unmapped error", 1'b1, err)
    $display("test registers done");
    apb(1'b1, `GDBIRQ_OFS_DEBOUNCE, 32'h0020_0501);
    apb(1'b1, `GDBIRQ_OFS_POLARITY, 32'h0004_0018);
    apb(1'b1, `GDBIRQ_OFS_SENSE, 32'h0000_0010);
    repeat (100) @(posedge ref_clk);
    apb(1'b1, `GDBIRQ_OFS_STATUS, 32'h0000_ffff);
    chkrd(`GDBIRQ_OFS_RAW, 32'h0, "raw after config");
    apb(1'b1, `GDBIRQ_OFS_IRQ_SET, 32'h0000_001d);
    chkrd(`GDBIRQ_OFS_IRQ_MASK, 32'h0000_001d, "mask after set");
    `CHK("irq idle", 1'b0, irqOut)
    level <= 16'hffe0;
    repeat (6) @(posedge ref_clk);
    chkrd(`GDBIRQ_OFS_RAW, 32'h0000_0007, "raw falling");
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0000_0005, "status falling");
    `CHK("irq pending", 1'b1, irqOut)
    apb(1'b1, `GDBIRQ_OFS_STATUS, 32'h0);
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0000_0005, "write zero no effect");
    apb(1'b1, `GDBIRQ_OFS_STATUS, 32'h0000_ffff);
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0, "status cleared");
    `CHK("irq cleared", 1'b0, irqOut)
    $display("test falling done");
    level <= 16'hffff;
    repeat (6) @(posedge ref_clk);
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0000_001c, "status rising");
    apb(1'b1, `GDBIRQ_OFS_STATUS, 32'h0000_ffff);
    repeat (3) @(posedge ref_clk);
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0000_0010, "level re-sets");
    apb(1'b1, `GDBIRQ_OFS_IRQ_CLR, 32'h0000_0010);
    chkrd(`GDBIRQ_OFS_IRQ_MASK, 32'h0000_000d, "mask after clear");
    apb(1'b1, `GDBIRQ_OFS_STATUS, 32'h0000_ffff);
    repeat (3) @(posedge ref_clk);
    chkrd(`GDBIRQ_OFS_RAW, 32'h0000_0010, "raw disabled pin");
    chkrd(`GDBIRQ_OFS_STATUS, 32'h0, "status disabled pin");
    $display("test rising and level done");
    pulseGo <= 1'b1;
    @(posedge ref_clk);
    pulseGo <= 1'b0;
    repeat (30) @(posedge ref_clk);
    `CHK("bounce state", 1'b1, pinState[5])
    apb(1'b0, `GDBIRQ_OFS_RAW, 32'h0);
    `CHK("bounce raw", 1'b0, rd[5])
    level <= 16'hffdf;
    repeat (7) @(posedge ref_clk);
    `CHK("filter early", 1'b1, pinState[5])
    repeat (13) @(posedge ref_clk);
    `CHK("filter late", 1'b0, pinState[5])
    apb(1'b0, `GDBIRQ_OFS_RAW, 32'h0);
    `CHK("filtered edge raw", 1'b1, rd[5])
    $display("test debounce done");
    stop_test();
  end
endmodule : tb_top
